/* pls_label_select.sv */
// Purpose: attach partition id, monitor group and space bit to requests
// Assumes: i_clk 40 MHz, i_rst_n async active low, inputs synchronous
// Notes: system-register port is a plain strobe port, no bus
`timescale 1ns/1ps
module pls_label_select #(
  parameter int PID_W = pls_pkg::PID_W,
  parameter int PMG_W = pls_pkg::PMG_W
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // current execution context
  input wire logic [1:0] i_cur_level,
  input wire logic i_nonsecure,
  input wire logic i_host_hyp_mode,
  input wire logic i_guest_app_lock,
  input wire logic i_lvl0_virt_map_en,
  input wire logic i_lvl1_virt_map_en,
  input wire logic i_lower_level_trap,
  input wire logic i_app_reg_hyp_trap,
  input wire logic i_guest_reg_hyp_trap,
  // memory request in
  input wire logic i_req_valid,
  input wire pls_pkg::pls_req_type i_req_kind,
  input wire logic i_req_unpriv,
  // system-register access port
  input wire logic i_sys_wr,
  input wire logic i_sys_rd,
  input wire logic [2:0] i_sys_sel,
  input wire logic [63:0] i_sys_wdata,
  // labelled request out
  output logic o_req_valid,
  output logic [PID_W-1:0] o_partition_id,
  output logic [PMG_W-1:0] o_monitor_group,
  output logic o_space_bit,
  output logic o_virt_map,
  // system-register answer
  output logic [63:0] o_sys_rdata,
  output logic o_sys_trap
);

  logic [63:0] app_label_reg;
  logic [63:0] guest_os_label_reg;
  logic [63:0] hypervisor_label_reg;
  logic [63:0] monitor_label_reg;

  // map a selector onto the physical register it reaches
  logic [2:0] phys_sel;
  logic allowed;
  logic [63:0] rd_mux;

  always_comb begin
    phys_sel = i_sys_sel;
    if (i_sys_sel == pls_pkg::SEL_GUEST && i_host_hyp_mode) begin
      phys_sel = pls_pkg::SEL_HYP;
    end else if (i_sys_sel == pls_pkg::SEL_GUEST_ALIAS) begin
      phys_sel = pls_pkg::SEL_GUEST;
    end
  end

  // permission check, done on the selector as named by software
  always_comb begin
    allowed = 1'b0;
    case (i_sys_sel)
      pls_pkg::SEL_APP: begin
        if (i_lower_level_trap) begin
          allowed = (i_cur_level == pls_pkg::LVL3);
        end else if (i_app_reg_hyp_trap) begin
          allowed = (i_cur_level >= pls_pkg::LVL2);
        end else begin
          allowed = (i_cur_level >= pls_pkg::LVL1);
        end
      end
      pls_pkg::SEL_GUEST: begin
        if (i_host_hyp_mode && i_cur_level >= pls_pkg::LVL2) begin
          // redirected name follows the hyp register's gate
          allowed = i_lower_level_trap ? (i_cur_level == pls_pkg::LVL3)
                                       : 1'b1;
        end else if (i_lower_level_trap) begin
          allowed = (i_cur_level == pls_pkg::LVL3);
        end else if (i_guest_reg_hyp_trap) begin
          allowed = (i_cur_level >= pls_pkg::LVL2);
        end else begin
          allowed = (i_cur_level >= pls_pkg::LVL1);
        end
      end
      pls_pkg::SEL_HYP: begin
        allowed = i_lower_level_trap ? (i_cur_level == pls_pkg::LVL3)
                                     : (i_cur_level >= pls_pkg::LVL2);
      end
      pls_pkg::SEL_MON: begin
        allowed = (i_cur_level == pls_pkg::LVL3);
      end
      pls_pkg::SEL_GUEST_ALIAS: begin
        // only meaningful to a host hypervisor at level 2 or above
        allowed = i_host_hyp_mode && (i_cur_level >= pls_pkg::LVL2) &&
                  (!i_lower_level_trap || i_cur_level == pls_pkg::LVL3);
      end
      default: allowed = 1'b0;
    endcase
  end

  logic do_wr;
  assign do_wr = i_sys_wr && allowed;

  // one process per label register keeps write enables obvious
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      app_label_reg <= pls_pkg::LABEL_RST;
    end else if (do_wr && phys_sel == pls_pkg::SEL_APP) begin
      app_label_reg <= i_sys_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      guest_os_label_reg <= pls_pkg::LABEL_RST;
    end else if (do_wr && phys_sel == pls_pkg::SEL_GUEST) begin
      guest_os_label_reg <= i_sys_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hypervisor_label_reg <= pls_pkg::LABEL_RST;
    end else if (do_wr && phys_sel == pls_pkg::SEL_HYP) begin
      hypervisor_label_reg <= i_sys_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      monitor_label_reg <= pls_pkg::LABEL_RST;
    end else if (do_wr && phys_sel == pls_pkg::SEL_MON) begin
      monitor_label_reg <= i_sys_wdata;
    end
  end

  always_comb begin
    case (phys_sel)
      pls_pkg::SEL_APP: rd_mux = app_label_reg;
      pls_pkg::SEL_GUEST: rd_mux = guest_os_label_reg;
      pls_pkg::SEL_HYP: rd_mux = hypervisor_label_reg;
      pls_pkg::SEL_MON: rd_mux = monitor_label_reg;
      default: rd_mux = 64'h0000_0000_0000_0000;
    endcase
  end

  // read data and trap flag registered, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_rdata <= 64'h0000_0000_0000_0000;
      o_sys_trap <= 1'b0;
    end else begin
      o_sys_trap <= (i_sys_wr || i_sys_rd) && !allowed;
      if (i_sys_rd && allowed) begin
        o_sys_rdata <= rd_mux;
      end else begin
        o_sys_rdata <= 64'h0000_0000_0000_0000;
      end
    end
  end

  // source register and mapping choice for requests
  logic [63:0] src_reg;
  logic map_next;

  always_comb begin
    src_reg = monitor_label_reg;
    map_next = 1'b0;
    if (i_req_kind == pls_pkg::PLS_REQ_NESTED) begin
      src_reg = hypervisor_label_reg;
    end else begin
      // unprivileged flag deliberately ignored here
      case (i_cur_level)
        pls_pkg::LVL0: begin
          if (i_guest_app_lock) begin
            src_reg = guest_os_label_reg;
            map_next = i_lvl1_virt_map_en;
          end else begin
            src_reg = app_label_reg;
            map_next = i_lvl0_virt_map_en;
          end
        end
        pls_pkg::LVL1: begin
          src_reg = guest_os_label_reg;
          map_next = i_lvl1_virt_map_en;
        end
        pls_pkg::LVL2: src_reg = hypervisor_label_reg;
        pls_pkg::LVL3: src_reg = monitor_label_reg;
        default: src_reg = monitor_label_reg;
      endcase
    end
  end

  logic [PID_W-1:0] pid_next;
  logic [PMG_W-1:0] pmg_next;

  // id and group always come as a pair from the same register
  always_comb begin
    if (i_req_kind == pls_pkg::PLS_REQ_INSTR) begin
      pid_next = src_reg[pls_pkg::IPID_LSB +: PID_W];
      pmg_next = src_reg[pls_pkg::IPMG_LSB +: PMG_W];
    end else begin
      pid_next = src_reg[pls_pkg::DPID_LSB +: PID_W];
      pmg_next = src_reg[pls_pkg::DPMG_LSB +: PMG_W];
    end
  end

  // labels registered with the request: one cycle of latency
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req_valid <= 1'b0;
      o_partition_id <= '0;
      o_monitor_group <= '0;
      o_space_bit <= pls_pkg::SPACE_SECURE;
      o_virt_map <= 1'b0;
    end else begin
      o_req_valid <= i_req_valid;
      if (i_req_valid) begin
        o_partition_id <= pid_next;
        o_monitor_group <= pmg_next;
        o_space_bit <= i_nonsecure ? pls_pkg::SPACE_NONSECURE
                                   : pls_pkg::SPACE_SECURE;
        o_virt_map <= map_next;
      end
    end
  end

endmodule

/* pls_pkg.sv */
// Purpose: shared constants for the partition label select block
// Assumes: 16-bit partition ids, 8-bit monitor groups, 64-bit label regs
// Notes: label register layout is a local choice
package pls_pkg;
  localparam int PID_W = 16;
  localparam int PMG_W = 8;
  localparam int REG_W = 64;
  // label register field positions
  localparam int DPID_LSB = 0;
  localparam int IPID_LSB = 16;
  localparam int DPMG_LSB = 32;
  localparam int IPMG_LSB = 40;
  localparam logic [63:0] LABEL_RST = 64'h0000_0000_0000_0000;
  // exception levels
  localparam logic [1:0] LVL0 = 2'h0;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h2;
  localparam logic [1:0] LVL3 = 2'h3;
  // register selectors on the system-register port
  localparam logic [2:0] SEL_APP = 3'h0;
  localparam logic [2:0] SEL_GUEST = 3'h1;
  localparam logic [2:0] SEL_HYP = 3'h2;
  localparam logic [2:0] SEL_MON = 3'h3;
  localparam logic [2:0] SEL_GUEST_ALIAS = 3'h4;
  // space bit encodings
  localparam logic SPACE_SECURE = 1'b0;
  localparam logic SPACE_NONSECURE = 1'b1;
  // request kinds
  typedef enum logic [1:0] {
    PLS_REQ_DATA,
    PLS_REQ_INSTR,
    PLS_REQ_NESTED
  } pls_req_type;
endpackage

/* pls_label_select_sva.sv */
// Purpose: port properties of the partition label select block
// Assumes: one clock domain, async active-low reset
// Notes: attached by bind to every instance of the block
`timescale 1ns/1ps
module pls_label_select_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_cur_level,
  input wire logic i_nonsecure,
  input wire logic i_lower_level_trap,
  input wire logic i_req_valid,
  input wire logic i_sys_wr,
  input wire logic i_sys_rd,
  input wire logic [2:0] i_sys_sel,
  input wire logic o_req_valid,
  input wire logic o_space_bit,
  input wire logic o_virt_map,
  input wire logic [63:0] o_sys_rdata,
  input wire logic o_sys_trap
);
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_acc; i_sys_wr || i_sys_rd; endsequence
  sequence s_refused; o_sys_trap && o_sys_rdata == 64'h0; endsequence
  property p_valid; i_req_valid |=> o_req_valid; endproperty
  a_valid: assert property (p_valid) else $error("no answer");
  property p_idle; !i_req_valid |=> !o_req_valid; endproperty
  a_idle: assert property (p_idle) else $error("stray valid");
  property p_space;
    i_req_valid |=> o_space_bit == $past(i_nonsecure);
  endproperty
  a_space: assert property (p_space) else $error("space bit");
  property p_no_map; i_req_valid && i_cur_level[1] |=> !o_virt_map;
  endproperty
  a_no_map: assert property (p_no_map) else $error("map high");
  property p_mon;
    s_acc ##0 (i_sys_sel == 3'h3 && i_cur_level != 2'h3) |=> s_refused;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor open");
  property p_mon_ok;
    s_acc ##0 (i_sys_sel == 3'h3 && i_cur_level == 2'h3) |=> !o_sys_trap;
  endproperty
  a_mon_ok: assert property (p_mon_ok) else $error("mon shut");
  property p_hyp; s_acc ##0 (i_sys_sel == 3'h2 && !i_cur_level[1])
    |=> s_refused; endproperty
  a_hyp: assert property (p_hyp) else $error("hyp open");
  property p_app; s_acc ##0 (i_sys_sel == 3'h0 && i_cur_level == 2'h1
    && i_lower_level_trap) |=> s_refused; endproperty
  a_app: assert property (p_app) else $error("app open");
endmodule
bind pls_label_select pls_label_select_sva u_sva (.*);

/* pls_mem_sink.sv */
// Purpose: downstream memory component that accepts labelled requests
// Assumes: never stalls, so the block needs no back-pressure
// Notes: counts requests for the bench
`timescale 1ns/1ps
module pls_mem_sink (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  output logic [31:0] o_count
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_count <= 32'h0;
    else if (i_valid) o_count <= o_count + 32'h1;
  end
endmodule

/* pls_label_select_test.sv */
// Purpose: random and corner checks of partition label selection
// Assumes: 40 MHz clock, answers one cycle after each request
// Notes: one stimulus word per cycle drives every control input
`timescale 1ns/1ps
module pls_label_select_test;
  localparam logic [31:0] CRN [9] = '{32'h0003_4003, 32'h0003_4002,
    32'h0003_8403, 32'h0002_4082, 32'h0001_400A, 32'h0004_400A,
    32'h0000_0C01, 32'h0000_1401, 32'h0000_2401};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] w = 32'h0;
  logic [31:0] seed = 32'h2DD3;
  logic [2:0] sel = 3'h0;
  logic [1:0] kind = 2'h0;
  logic [63:0] sh [4];
  int num_errors = 0, checked = 0, nreq = 0;
  logic ov, osp, ovm, otr;
  logic [15:0] opid;
  logic [7:0] opmg;
  logic [63:0] ord;
  logic [31:0] cnt;
  always #12.5 clk = ~clk;
  pls_label_select uut (.i_clk(clk), .i_rst_n(rst_n), .i_cur_level(w[1:0]),
    .i_nonsecure(w[2]), .i_host_hyp_mode(w[3]), .i_guest_app_lock(w[4]),
    .i_lvl0_virt_map_en(w[5]), .i_lvl1_virt_map_en(w[6]),
    .i_lower_level_trap(w[7]), .i_app_reg_hyp_trap(w[8]),
    .i_guest_reg_hyp_trap(w[9]), .i_req_valid(w[10]),
    .i_req_kind(pls_pkg::pls_req_type'(kind)), .i_req_unpriv(w[13]),
    .i_sys_wr(w[14]), .i_sys_rd(w[15] & ~w[14]), .i_sys_sel(sel),
    .i_sys_wdata({w, ~w}), .o_req_valid(ov), .o_partition_id(opid),
    .o_monitor_group(opmg), .o_space_bit(osp), .o_virt_map(ovm),
    .o_sys_rdata(ord), .o_sys_trap(otr));
  pls_mem_sink sink (.i_clk(clk), .i_rst_n(rst_n), .i_valid(ov),
    .o_count(cnt));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // access allowed for selector s under context word v
  function automatic logic ok(input logic [31:0] v, input logic [2:0] s);
    logic t3;
    t3 = v[7] ? v[1:0] == 2'h3 : v[1];
    case (s)
      3'h0: ok = v[7] | v[8] ? t3 : v[1:0] != 2'h0;
      3'h1: ok = v[7] | v[9] | v[3] & v[1] ? t3 : v[1:0] != 2'h0;
      3'h2: ok = t3;
      3'h3: ok = v[1:0] == 2'h3;
      default: ok = v[3] & t3;
    endcase
  endfunction
  task automatic step(input logic [31:0] v);
    logic [63:0] r;
    logic a, rq, m;
    int t;
    w = v;
    sel = 3'(v[18:16] % 3'h5);
    kind = v[12:11] == 2'h3 ? 2'h0 : v[12:11];
    r = sh[kind == 2'h2 ? 2 : v[1:0] == 2'h0 ? int'(v[4]) : int'(v[1:0])];
    m = kind != 2'h2 && !v[1] && (v[1:0] == 2'h0 && !v[4] ? v[5] : v[6]);
    a = ok(v, sel);
    // host mode sends the guest name to the hyp register at any level
    t = sel == 3'h4 ? 1 : sel == 3'h1 && v[3] ? 2 : int'(sel);
    rq = v[15] & ~v[14];
    nreq += int'(v[10]);
    @(posedge clk);
    #1;
    chk(ov, v[10]);
    if (v[10]) begin
      chk(opid, kind == 2'h1 ? r[31:16] : r[15:0]);
      chk(opmg, kind == 2'h1 ? r[47:40] : r[39:32]);
      chk(osp, v[2]);
      chk(ovm, m);
    end
    chk(otr, (v[14] | rq) & ~a);
    chk(ord, rq & a ? sh[t] : 64'h0);
    if (v[14] & a) sh[t] = {v, ~v};
  endtask
  initial begin
    foreach (sh[j]) sh[j] = pls_pkg::LABEL_RST;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    foreach (CRN[k]) step(CRN[k]);
    repeat (2000) step(rnd());
    step(32'h0);
    for (int k = 0; k < 4 && cnt != 32'(nreq); k++) @(posedge clk);
    chk(cnt, 64'(nreq));
    end_sim();
  end
endmodule
